/* hdl/enc_eval_pkg.sv */
// shared constants and types for the encoder count pulse evaluator
package enc_eval_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    // filter delays in nanoseconds
    localparam int unsigned FILT_SHORT_NS   = 1_000;
    localparam int unsigned FILT_LONG_NS    = 15_000;
    localparam int unsigned FILT_SHORT_CYC  = (FILT_SHORT_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned FILT_LONG_CYC   = (FILT_LONG_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned FILT_CNT_W      = 9;
    localparam int unsigned NUM_TRACKS      = 4;
    localparam int unsigned CNT_W           = 32;

    // register map, word offsets as byte addresses
    localparam logic [7:0]  ADDR_CFG        = 8'h00;
    localparam logic [7:0]  ADDR_LOAD       = 8'h04;
    localparam logic [7:0]  ADDR_COUNT      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0C;

    // config field positions
    localparam int unsigned CFG_EVAL_LSB    = 0;
    localparam int unsigned CFG_POL_LSB     = 2;
    localparam int unsigned CFG_INV_BIT     = 4;
    localparam int unsigned CFG_FILT_BIT    = 5;
    localparam int unsigned CFG_IDX_BIT     = 6;
    localparam int unsigned CFG_PULSE_BIT   = 7;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        EVAL_SINGLE,
        EVAL_DOUBLE,
        EVAL_QUAD
    } eval_mode_t;

    typedef enum logic [1:0] {
        POL_SOURCING,
        POL_PUSH_PULL,
        POL_SINKING
    } in_pol_t;

    typedef struct packed {
        logic        pulse_mode;
        logic        index_en;
        logic        filt_long;
        logic        dir_invert;
        in_pol_t     polarity;
        eval_mode_t  eval;
    } cfg_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

/* hdl/input_filter.sv */
// per-track debounce filter with selectable settle time
`timescale 1ns/1ps
module input_filter
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  raw_i,
    input  wire logic  long_i,
    output logic       level_o
);
    logic [enc_eval_pkg::FILT_CNT_W-1:0] count;
    logic [enc_eval_pkg::FILT_CNT_W-1:0] limit;

    assign limit = long_i ? enc_eval_pkg::FILT_CNT_W'(enc_eval_pkg::FILT_LONG_CYC)
                          : enc_eval_pkg::FILT_CNT_W'(enc_eval_pkg::FILT_SHORT_CYC);

    // level moves only after input differs for the full settle time
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count   <= '0;
            level_o <= 1'b0;
        end
        else if (raw_i == level_o)
        begin
            count <= '0;
        end
        else if (count + 1'b1 >= limit)
        begin
            count   <= '0;
            level_o <= raw_i;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end
endmodule

/* hdl/encoder_count_pulse_evaluator.sv */
// encoder count pulse evaluator with counter and register port
//
// Overview of operation
// - direction comes from the quarter-period phase relation of tracks A and B
// - index pulse loads counter with load value only when index enabled
// - inversion setting swaps up and down for incremental encoders
// - pulse mode: sourcing floating up, asserted down; sinking floating up, pulled low down
// - inversion setting ignored in pulse-with-direction mode
// - inputs configurable as sourcing, push-pull or sinking
// - one filter setting for all tracks and digital input; 1 us or 15 us
// - short filter default passes 200 kHz; long filter limits to 20 kHz
// - no wire-break or short monitoring on count inputs
// - single evaluation: rising A only, B level selects direction
// - double evaluation: both A edges, B level selects direction
// - quadruple evaluation: all edges of A and B, both levels decide
// - double and quadruple only for incremental; pulse mode uses single
// - reset default is single evaluation
`timescale 1ns/1ps
module encoder_count_pulse_evaluator
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         track_a_i,
    input  wire logic         track_b_i,
    input  wire logic         track_n_i,
    input  wire logic         dig_in_i,
    input  wire logic [7:0]   addr_i,
    input  wire logic [31:0]  wdata_i,
    input  wire logic         wr_i,
    input  wire logic         rd_i,
    output logic [31:0]       rdata_o,
    output logic              up_pulse_o,
    output logic              down_pulse_o,
    output logic              dig_in_o
);
    enc_eval_pkg::cfg_t       cfg;
    enc_eval_pkg::reg_req_t   req;
    logic [31:0]              load_value;
    logic [31:0]              count;
    logic [31:0]              next_count;
    logic [enc_eval_pkg::NUM_TRACKS-1:0] raw;
    logic [enc_eval_pkg::NUM_TRACKS-1:0] filt;
    logic [enc_eval_pkg::NUM_TRACKS-1:0] sync1;
    logic [enc_eval_pkg::NUM_TRACKS-1:0] sync2;
    logic [enc_eval_pkg::NUM_TRACKS-1:0] prev;
    logic                     rise_a;
    logic                     fall_a;
    logic                     rise_n;
    logic                     a_lvl;
    logic                     b_lvl;
    logic                     next_up;
    logic                     next_down;
    logic                     quad_up;
    logic                     dir_down;
    logic                     sinking;
    logic                     pulse_down;
    logic                     quad_step;
    logic                     wr_cfg;
    logic                     wr_load;
    logic                     wr_count;
    logic [31:0]              next_rdata;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign raw = {dig_in_i, track_n_i, track_b_i, track_a_i};
    assign sinking = (cfg.polarity == enc_eval_pkg::POL_SINKING);

    // one filter per input, all sharing the same setting
    genvar gi;
    generate
        for (gi = 0; gi < enc_eval_pkg::NUM_TRACKS; gi++)
        begin : g_track
            input_filter u_filter
            (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .raw_i   (raw[gi]),
                .long_i  (cfg.filt_long),
                .level_o (filt[gi])
            );
        end
    endgenerate

    // two-stage synchroniser on the filtered levels
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= filt;
            sync2 <= sync1;
        end
    end

    // previous synchronised levels for edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev <= '0;
        end
        else
        begin
            prev <= sync2;
        end
    end

    // levels are used unchanged for every polarity, sinking only flips pulse direction; no line monitoring at all
    assign a_lvl  = sync2[0];
    assign b_lvl  = sync2[1];
    assign rise_a = sync2[0] & ~prev[0];
    assign fall_a = ~sync2[0] & prev[0];
    assign rise_n = sync2[2] & ~prev[2];

    // pulse mode direction from the b level and input polarity only
    always_comb
    begin
        pulse_down = b_lvl;
        if (sinking)
        begin
            pulse_down = ~b_lvl;
        end
    end

    // quadrature steps from {old a, old b, new a, new b}
    always_comb
    begin
        quad_step = 1'b0;
        quad_up   = 1'b0;
        case ({prev[0], prev[1], a_lvl, b_lvl})
            // a leads b: up
            4'h2, 4'hB, 4'hD, 4'h4:
            begin
                quad_step = 1'b1;
                quad_up   = 1'b1;
            end
            // b leads a: down
            4'h1, 4'h7, 4'hE, 4'h8:
            begin
                quad_step = 1'b1;
            end
            default:
            begin
                // no move, or both tracks at once, is not a step
                quad_step = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_up   = 1'b0;
        next_down = 1'b0;
        dir_down  = 1'b0;
        if (cfg.pulse_mode)
        begin
            // direction from B level and polarity only, single edge on A
            dir_down  = pulse_down;
            next_up   = rise_a & ~dir_down;
            next_down = rise_a & dir_down;
        end
        else
        begin
            case (cfg.eval)
                enc_eval_pkg::EVAL_DOUBLE:
                begin
                    // on rising A, B low is up; falling A, B high is up
                    dir_down  = rise_a ? b_lvl : ~b_lvl;
                    next_up   = (rise_a | fall_a) & ~dir_down;
                    next_down = (rise_a | fall_a) & dir_down;
                end
                enc_eval_pkg::EVAL_QUAD:
                begin
                    dir_down  = ~quad_up;
                    next_up   = quad_step & quad_up;
                    next_down = quad_step & ~quad_up;
                end
                default:
                begin
                    dir_down  = b_lvl;
                    next_up   = rise_a & ~dir_down;
                    next_down = rise_a & dir_down;
                end
            endcase
            if (cfg.dir_invert)
            begin
                {next_up, next_down} = {next_down, next_up};
            end
        end
    end

    always_comb
    begin
        next_count = count;
        // bus write beats index load, index load beats a count step
        if (wr_count)
        begin
            next_count = req.wdata;
        end
        else if (cfg.index_en && rise_n)
        begin
            next_count = load_value;
        end
        else if (next_up)
        begin
            next_count = count + 32'h0000_0001;
        end
        else if (next_down)
        begin
            next_count = count - 32'h0000_0001;
        end
    end

    // position counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    // one-cycle count pulses toward the counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            up_pulse_o   <= 1'b0;
            down_pulse_o <= 1'b0;
        end
        else
        begin
            up_pulse_o   <= next_up;
            down_pulse_o <= next_down;
        end
    end

    // filtered and synchronised digital input
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dig_in_o <= 1'b0;
        end
        else
        begin
            dig_in_o <= sync2[3];
        end
    end

    // write strobe decode, unmapped writes are dropped
    always_comb
    begin
        wr_cfg   = 1'b0;
        wr_load  = 1'b0;
        wr_count = 1'b0;
        if (!req.wr)
        begin
            wr_cfg = 1'b0;
        end
        else if (req.addr == enc_eval_pkg::ADDR_CFG)
        begin
            wr_cfg = 1'b1;
        end
        else if (req.addr == enc_eval_pkg::ADDR_LOAD)
        begin
            wr_load = 1'b1;
        end
        else if (req.addr == enc_eval_pkg::ADDR_COUNT)
        begin
            wr_count = 1'b1;
        end
    end

    // configuration register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg <= enc_eval_pkg::cfg_t'(enc_eval_pkg::CFG_RESET[7:0]);
        end
        else if (wr_cfg)
        begin
            cfg <= enc_eval_pkg::cfg_t'(req.wdata[7:0]);
        end
    end

    // value taken by the counter on an enabled index pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            load_value <= '0;
        end
        else if (wr_load)
        begin
            load_value <= req.wdata;
        end
    end

    // read select, zero when idle or unmapped
    always_comb
    begin
        next_rdata = '0;
        if (!req.rd)
        begin
            next_rdata = '0;
        end
        else if (req.addr == enc_eval_pkg::ADDR_CFG)
        begin
            next_rdata = {24'h00_0000, cfg};
        end
        else if (req.addr == enc_eval_pkg::ADDR_LOAD)
        begin
            next_rdata = load_value;
        end
        else if (req.addr == enc_eval_pkg::ADDR_COUNT)
        begin
            next_rdata = count;
        end
        else if (req.addr == enc_eval_pkg::ADDR_STATUS)
        begin
            next_rdata = {28'h000_0000, sync2};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= next_rdata;
        end
    end
endmodule

/* test/enc_eval_checker.sv */
// assertion checker for the encoder count pulse evaluator
`timescale 1ns/1ps
module enc_eval_checker
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        track_a_i,
    input  wire logic        track_b_i,
    input  wire logic        track_n_i,
    input  wire logic        dig_in_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        up_pulse_o,
    input  wire logic        down_pulse_o,
    input  wire logic        dig_in_o
);
    enc_eval_pkg::cfg_t cfg_q;
    logic               prev_a;
    logic               prev_b;
    logic               last_a;
    logic [9:0]         quiet;
    logic               any_p;
    logic               fwd;
    logic               sgl;

    assign any_p = up_pulse_o || down_pulse_o;
    assign fwd   = last_a ? (track_a_i != track_b_i) : (track_a_i == track_b_i);
    assign sgl   = cfg_q.eval == enc_eval_pkg::EVAL_SINGLE && !cfg_q.filt_long && !cfg_q.pulse_mode;

    // shadow of the configuration word
    always_ff @(posedge clk_i)
        if (rst_i)
            cfg_q <= '0;
        else if (wr_i && addr_i == enc_eval_pkg::ADDR_CFG)
            cfg_q <= enc_eval_pkg::cfg_t'(wdata_i[7:0]);

    // which track moved last, and how long the tracks stayed quiet
    always_ff @(posedge clk_i)
    begin
        prev_a <= rst_i ? 1'b0 : track_a_i;
        prev_b <= rst_i ? 1'b0 : track_b_i;
        if (track_a_i != prev_a)
            last_a <= 1'b1;
        else if (track_b_i != prev_b)
            last_a <= 1'b0;
        if (rst_i || track_a_i != prev_a || track_b_i != prev_b)
            quiet <= '0;
        else if (quiet != '1)
            quiet <= quiet + 10'h001;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rise_held;
        $rose(track_a_i) && sgl ##1 track_a_i [*8];
    endsequence

    AST_PULSE_EXCL: assert property (!(up_pulse_o && down_pulse_o))
        else $error("up and down pulse together");
    AST_PULSE_ONE: assert property (up_pulse_o |=> !up_pulse_o)
        else $error("up pulse longer than one cycle");
    AST_FILT_SHORT: assert property (any_p && !cfg_q.filt_long |-> quiet >= 18 && quiet <= 28)
        else $error("pulse outside short filter window");
    AST_FILT_LONG: assert property (any_p && cfg_q.filt_long |-> quiet >= 298 && quiet <= 308)
        else $error("pulse outside long filter window");
    AST_INC_DIR: assert property (any_p && !cfg_q.pulse_mode |-> up_pulse_o == (fwd ^ cfg_q.dir_invert))
        else $error("wrong incremental direction");
    AST_SINGLE_EDGE: assert property (any_p && sgl |-> last_a && track_a_i)
        else $error("single mode pulse not from rising track a");
    AST_DOUBLE_EDGE: assert property (any_p && !cfg_q.pulse_mode && cfg_q.eval == enc_eval_pkg::EVAL_DOUBLE |-> last_a)
        else $error("double mode pulse from track b");
    AST_PULSE_DIR: assert property (any_p && cfg_q.pulse_mode |->
        up_pulse_o == (track_b_i == (cfg_q.polarity == enc_eval_pkg::POL_SINKING)))
        else $error("wrong pulse mode direction");
    AST_PULSE_SINGLE: assert property (any_p && cfg_q.pulse_mode |-> last_a && track_a_i)
        else $error("pulse mode pulse not from rising track a");
    AST_SINGLE_COUNTS: assert property (s_rise_held |-> ##[10:24] any_p)
        else $error("rising track a not counted");
    AST_DOWN_ONE: assert property (down_pulse_o |=> !down_pulse_o)
        else $error("down pulse longer than one cycle");
    AST_READ_IDLE: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");
    AST_DIG_PATH: assert property ($changed(dig_in_o) |-> dig_in_o == $past(dig_in_i, 4))
        else $error("digital output level not from filtered input");
endmodule

bind encoder_count_pulse_evaluator enc_eval_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .track_a_i(track_a_i),
    .track_b_i(track_b_i), .track_n_i(track_n_i), .dig_in_i(dig_in_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .up_pulse_o(up_pulse_o), .down_pulse_o(down_pulse_o),
    .dig_in_o(dig_in_o));

/* test/encoder_model.sv */
// incremental encoder and pulse generator driving the count tracks
`timescale 1ns/1ps
module encoder_model
(
    input  wire logic clk_i,
    output logic      a_o,
    output logic      b_o,
    output logic      n_o
);
    initial
    begin
        a_o = 1'b0;
        b_o = 1'b0;
        n_o = 1'b0;
    end

    // quarter-period steps, forward means a leads b
    task automatic step(input logic fwd, input int n, input int hold);
        repeat (n)
        begin
            @(posedge clk_i);
            if ((a_o == b_o) == fwd)
                a_o <= ~a_o;
            else
                b_o <= ~b_o;
            repeat (hold) @(posedge clk_i);
        end
    endtask

    task automatic pulse(input int width);
        @(posedge clk_i);
        a_o <= 1'b1;
        repeat (width) @(posedge clk_i);
        a_o <= 1'b0;
        repeat (width) @(posedge clk_i);
    endtask

    task automatic dir(input logic v);
        @(posedge clk_i);
        b_o <= v;
        repeat (40) @(posedge clk_i);
    endtask

    task automatic index(input int width);
        @(posedge clk_i);
        n_o <= 1'b1;
        repeat (width) @(posedge clk_i);
        n_o <= 1'b0;
        repeat (width) @(posedge clk_i);
    endtask
endmodule

/* test/encoder_count_pulse_evaluator_tb_top.sv */
// self-checking bench for the encoder count pulse evaluator
`timescale 1ns/1ps
module encoder_count_pulse_evaluator_tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        ta;
    logic        tb;
    logic        tn;
    logic        dig;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        up_p;
    logic        dn_p;
    logic        dig_o;
    int          num_errors;
    int          checks_done;
    int          n_up;
    int          n_dn;
    int          cycles;

    encoder_model i_enc (.clk_i(clk_i), .a_o(ta), .b_o(tb), .n_o(tn));
    encoder_count_pulse_evaluator i_dut (.clk_i(clk_i), .rst_i(rst_i), .track_a_i(ta), .track_b_i(tb),
        .track_n_i(tn), .dig_in_i(dig), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .up_pulse_o(up_p), .down_pulse_o(dn_p), .dig_in_o(dig_o));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        n_up += int'(up_p === 1'b1);
        n_dn += int'(dn_p === 1'b1);
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    task automatic setup(input logic [31:0] cfg);
        wr_reg(enc_eval_pkg::ADDR_CFG, cfg);
        wr_reg(enc_eval_pkg::ADDR_COUNT, 32'h0000_0000);
        n_up = 0;
        n_dn = 0;
    endtask

    task automatic t_reset();
        rd_reg("cfg", enc_eval_pkg::ADDR_CFG, enc_eval_pkg::CFG_RESET);
        rd_reg("count", enc_eval_pkg::ADDR_COUNT, 32'h0000_0000);
        rd_reg("unmapped", 8'h10, 32'h0000_0000);
    endtask

    task automatic t_incr();
        for (int e = 0; e < 3; e++)
            for (int inv = 0; inv < 2; inv++)
            begin
                setup(32'(e | (inv << 4)));
                i_enc.step(1'b1, 8, 40);
                i_enc.step(1'b0, 4, 40);
                rd_reg("count", enc_eval_pkg::ADDR_COUNT, 32'((inv ? -1 : 1) << e));
                chk("ups", 32'((inv ? 1 : 2) << e), 32'(n_up));
                chk("downs", 32'((inv ? 2 : 1) << e), 32'(n_dn));
            end
    endtask

    task automatic t_pulse();
        for (int p = 0; p < 3; p++)
        begin
            setup(32'h0000_0092 | 32'(p << 2));
            i_enc.dir(1'b0);
            repeat (3) i_enc.pulse(40);
            i_enc.dir(1'b1);
            repeat (2) i_enc.pulse(40);
            i_enc.dir(1'b0);
            rd_reg("pulse count", enc_eval_pkg::ADDR_COUNT, p == 2 ? 32'hFFFF_FFFF : 32'h0000_0001);
        end
    endtask

    task automatic t_index();
        setup(32'h0000_0000);
        wr_reg(enc_eval_pkg::ADDR_LOAD, 32'h1234_5678);
        i_enc.index(40);
        rd_reg("index off", enc_eval_pkg::ADDR_COUNT, 32'h0000_0000);
        wr_reg(enc_eval_pkg::ADDR_CFG, 32'h0000_0040);
        i_enc.index(40);
        rd_reg("index on", enc_eval_pkg::ADDR_COUNT, 32'h1234_5678);
    endtask

    task automatic t_filter();
        setup(32'h0000_0000);
        i_enc.pulse(5);
        rd_reg("short glitch", enc_eval_pkg::ADDR_COUNT, 32'h0000_0000);
        @(posedge clk_i);
        dig <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("dig early", 32'h0000_0000, 32'(dig_o));
        repeat (30) @(posedge clk_i);
        chk("dig short", 32'h0000_0001, 32'(dig_o));
        wr_reg(enc_eval_pkg::ADDR_CFG, 32'h0000_0020);
        i_enc.pulse(100);
        rd_reg("long glitch", enc_eval_pkg::ADDR_COUNT, 32'h0000_0000);
        i_enc.pulse(400);
        rd_reg("long count", enc_eval_pkg::ADDR_COUNT, 32'h0000_0001);
        @(posedge clk_i);
        dig <= 1'b0;
        repeat (100) @(posedge clk_i);
        chk("dig long early", 32'h0000_0001, 32'(dig_o));
        repeat (250) @(posedge clk_i);
        chk("dig long", 32'h0000_0000, 32'(dig_o));
    endtask

    initial
    begin
        rst_i = 1'b1;
        dig   = 1'b0;
        addr  = 8'h00;
        wdata = 32'h0000_0000;
        wr    = 1'b0;
        rd    = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_incr();
        t_pulse();
        t_index();
        t_filter();
        end_sim();
    end
endmodule
